/* File: design/ddr_command_timing_guard.sv */
`timescale 1ns/10ps
`default_nettype none
module ddr_command_timing_guard
   import ddr_guard_pkg::*;
(
   input  wire logic              core_clk,
   input  wire logic              rst,
   input  wire logic              fast_grade,
   input  wire logic              req_valid,
   input  wire command_type       req_cmd,
   input  wire logic [1:0]        req_bank,
   input  wire logic [12:0]       req_addr,
   output logic                   req_done,
   output logic                   mem_ck,
   output logic                   mem_ck_n,
   output logic                   mem_cke,
   output logic                   mem_cs_n,
   output logic                   mem_ras_n,
   output logic                   mem_cas_n,
   output logic                   mem_we_n,
   output logic [1:0]             mem_ba,
   output logic [12:0]            mem_addr,
   output logic                   strobe_out,
   output logic                   strobe_oe,
   output logic                   refresh_due,
   output logic [NUM_BANKS-1:0]   bank_overdue
);

   timer_type        access_cnt [NUM_BANKS];
   timer_type        pre_cnt    [NUM_BANKS];
   timer_type        act_cnt    [NUM_BANKS];
   timer_type        open_cnt   [NUM_BANKS];
   logic [NUM_BANKS-1:0] bank_open;
   timer_type        rrd_cnt, rfc_cnt, mrd_cnt, wtr_cnt, xsnr_cnt, xsrd_cnt, wbusy_cnt, refi_cnt;
   logic             in_self_refresh;
   logic             allowed;
   logic             accept;
   logic             slot;
   logic             all_idle;
   strobe_state_type strobe_state;

   function automatic timer_type dec(input timer_type v);
      return (v == '0) ? '0 : v - 1'b1;
   endfunction

   // Count seen at an edge m cycles after loading is n-m, so load n-1
   function automatic timer_type ld(input int n);
      return (n > 0) ? timer_type'(n - 1) : '0;
   endfunction

   function automatic timer_type grade(input logic fast, input int f, input int s);
      return ld(fast ? f : s);
   endfunction

   function automatic timer_type tmax(input timer_type a, input timer_type b);
      return (a > b) ? a : b;
   endfunction

   // Commands leave on the edge where the memory clock falls, so pins are settled at its rise
   assign slot   = mem_ck;
   assign accept = req_valid && slot && allowed && !req_done;

   always_comb begin
      all_idle = 1'b1;
      for (int b = 0; b < NUM_BANKS; b++) begin
         if (bank_open[b] || act_cnt[b] != '0) begin
            all_idle = 1'b0;
         end
      end
   end

   // Gate each command on every spacing that still runs
   always_comb begin
      allowed = 1'b0;
      if (in_self_refresh) begin
         allowed = (req_cmd == CMD_SELF_REFRESH_EXIT);
      end else if (mrd_cnt == '0) begin
         case (req_cmd)
            CMD_ACTIVATE:
               allowed = !bank_open[req_bank] && act_cnt[req_bank] == '0
                         && rrd_cnt == '0 && rfc_cnt == '0 && xsnr_cnt == '0;
            CMD_READ:
               allowed = bank_open[req_bank] && access_cnt[req_bank] == '0
                         && wtr_cnt == '0 && xsrd_cnt == '0;
            CMD_WRITE, CMD_WRITE_AP:
               allowed = bank_open[req_bank] && access_cnt[req_bank] == '0
                         && wbusy_cnt == '0 && xsnr_cnt == '0
                         && (req_cmd == CMD_WRITE || pre_cnt[req_bank] == '0);
            CMD_PRECHARGE:
               allowed = bank_open[req_bank] && pre_cnt[req_bank] == '0
                         && wbusy_cnt == '0 && xsnr_cnt == '0;
            CMD_REFRESH, CMD_SELF_REFRESH_ENTER:
               allowed = all_idle && rfc_cnt == '0 && xsnr_cnt == '0;
            CMD_MODE_SET:
               allowed = all_idle && rfc_cnt == '0 && xsnr_cnt == '0;
            default:
               allowed = 1'b0;
         endcase
      end
   end

   // Memory clock by halving the core clock
   always_ff @(posedge core_clk) begin
      if (rst) begin
         mem_ck   <= 1'b0;
         mem_ck_n <= 1'b1;
      end else begin
         mem_ck   <= !mem_ck;
         mem_ck_n <= mem_ck;
      end
   end

   // Command pins: a command for one memory clock, NOP at other slots
   always_ff @(posedge core_clk) begin
      if (rst) begin
         {mem_cs_n, mem_ras_n, mem_cas_n, mem_we_n} <= PINS_NOP;
         mem_ba   <= '0;
         mem_addr <= '0;
         mem_cke  <= 1'b0;
         req_done <= 1'b0;
      end else begin
         req_done <= accept;
         if (slot) begin
            {mem_cs_n, mem_ras_n, mem_cas_n, mem_we_n} <= PINS_NOP;
         end
         if (accept) begin
            mem_ba   <= req_bank;
            mem_addr <= req_addr;
            case (req_cmd)
               CMD_ACTIVATE:  {mem_cs_n, mem_ras_n, mem_cas_n, mem_we_n} <= PINS_ACTIVATE;
               CMD_READ:      {mem_cs_n, mem_ras_n, mem_cas_n, mem_we_n} <= PINS_READ;
               CMD_WRITE, CMD_WRITE_AP: begin
                  {mem_cs_n, mem_ras_n, mem_cas_n, mem_we_n} <= PINS_WRITE;
                  mem_addr[AUTO_PRE_BIT] <= (req_cmd == CMD_WRITE_AP);
               end
               CMD_PRECHARGE: begin
                  {mem_cs_n, mem_ras_n, mem_cas_n, mem_we_n} <= PINS_PRECHARGE;
                  mem_addr[AUTO_PRE_BIT] <= 1'b0;
               end
               CMD_REFRESH:   {mem_cs_n, mem_ras_n, mem_cas_n, mem_we_n} <= PINS_REFRESH;
               CMD_SELF_REFRESH_ENTER: begin
                  {mem_cs_n, mem_ras_n, mem_cas_n, mem_we_n} <= PINS_REFRESH;
                  mem_cke <= 1'b0;
               end
               CMD_SELF_REFRESH_EXIT: mem_cke <= 1'b1;
               CMD_MODE_SET:  {mem_cs_n, mem_ras_n, mem_cas_n, mem_we_n} <= PINS_MODE_SET;
               default:       {mem_cs_n, mem_ras_n, mem_cas_n, mem_we_n} <= PINS_NOP;
            endcase
         end else if (!in_self_refresh && !mem_cke) begin
            mem_cke <= 1'b1;   // Clock enable rises after reset
         end
      end
   end

   // Per-bank timers and open state
   always_ff @(posedge core_clk) begin
      if (rst) begin
         bank_open <= '0;
         for (int b = 0; b < NUM_BANKS; b++) begin
            access_cnt[b] <= '0;
            pre_cnt[b]    <= '0;
            act_cnt[b]    <= '0;
            open_cnt[b]   <= '0;
         end
      end else begin
         for (int b = 0; b < NUM_BANKS; b++) begin
            access_cnt[b] <= dec(access_cnt[b]);
            pre_cnt[b]    <= dec(pre_cnt[b]);
            act_cnt[b]    <= dec(act_cnt[b]);
            // Saturate so a forgotten row stays flagged rather than wrapping
            open_cnt[b]   <= bank_open[b] ? open_cnt[b] + timer_type'(~&open_cnt[b]) : '0;
            if (accept && req_bank == 2'(b)) begin
               case (req_cmd)
                  CMD_ACTIVATE: begin
                     bank_open[b]  <= 1'b1;
                     access_cnt[b] <= grade(fast_grade, ACCESS_CYC_FAST, ACCESS_CYC_SLOW);
                     pre_cnt[b]    <= grade(fast_grade, RAS_CYC_FAST, RAS_CYC_SLOW);
                     act_cnt[b]    <= grade(fast_grade, RC_CYC_FAST, RC_CYC_SLOW);
                     open_cnt[b]   <= '0;
                  end
                  CMD_PRECHARGE: begin
                     bank_open[b] <= 1'b0;
                     act_cnt[b]   <= tmax(dec(act_cnt[b]), grade(fast_grade, RP_CYC_FAST, RP_CYC_SLOW));
                  end
                  CMD_WRITE_AP: begin
                     bank_open[b] <= 1'b0;
                     act_cnt[b]   <= tmax(dec(act_cnt[b]), grade(fast_grade, DAL_CYC_FAST, DAL_CYC_SLOW));
                  end
                  default: begin
                  end
               endcase
            end
         end
      end
   end

   // Global spacing timers
   always_ff @(posedge core_clk) begin
      if (rst) begin
         {rrd_cnt, rfc_cnt, mrd_cnt, wtr_cnt, wbusy_cnt, xsnr_cnt, xsrd_cnt} <= '0;
         in_self_refresh <= 1'b0;
      end else begin
         rrd_cnt   <= accept && req_cmd == CMD_ACTIVATE
                      ? grade(fast_grade, RRD_CYC_FAST, RRD_CYC_SLOW) : dec(rrd_cnt);
         rfc_cnt   <= accept && req_cmd == CMD_REFRESH
                      ? grade(fast_grade, RFC_CYC_FAST, RFC_CYC_SLOW) : dec(rfc_cnt);
         mrd_cnt   <= accept && req_cmd == CMD_MODE_SET ? ld(MRD_CYC) : dec(mrd_cnt);
         wtr_cnt   <= accept && (req_cmd == CMD_WRITE || req_cmd == CMD_WRITE_AP)
                      ? grade(fast_grade, WTR_CYC_FAST, WTR_CYC_SLOW) : dec(wtr_cnt);
         wbusy_cnt <= accept && (req_cmd == CMD_WRITE || req_cmd == CMD_WRITE_AP)
                      ? ld(WBUSY_CYC) : dec(wbusy_cnt);
         if (accept && req_cmd == CMD_SELF_REFRESH_EXIT) begin
            xsnr_cnt <= ld(XSNR_CYC);
            xsrd_cnt <= ld(XSRD_CYC);
         end else begin
            xsnr_cnt <= dec(xsnr_cnt);
            xsrd_cnt <= dec(xsrd_cnt);
         end
         if (accept && req_cmd == CMD_SELF_REFRESH_ENTER) begin
            in_self_refresh <= 1'b1;
         end else if (accept && req_cmd == CMD_SELF_REFRESH_EXIT) begin
            in_self_refresh <= 1'b0;
         end
      end
   end

   // Refresh interval and overlong-open warnings; self refresh keeps rows alive itself
   always_ff @(posedge core_clk) begin
      if (rst) begin
         refi_cnt     <= '0;
         refresh_due  <= 1'b0;
         bank_overdue <= '0;
      end else begin
         if (accept && (req_cmd == CMD_REFRESH || req_cmd == CMD_SELF_REFRESH_EXIT)) begin
            refi_cnt    <= '0;
            refresh_due <= 1'b0;
         end else if (!in_self_refresh) begin
            refi_cnt <= (refi_cnt == timer_type'(REFI_CYC)) ? refi_cnt : refi_cnt + 1'b1;
            if (refi_cnt >= ld(REFI_CYC)) begin
               refresh_due <= 1'b1;
            end
         end
         for (int b = 0; b < NUM_BANKS; b++) begin
            bank_overdue[b] <= bank_open[b] && open_cnt[b] >= ld(RAS_MAX_CYC);
         end
      end
   end

   // Write strobe: preamble from the sampling rise, high on the next rise, low on the following fall
   always_ff @(posedge core_clk) begin
      if (rst) begin
         strobe_state <= STROBE_IDLE;
         strobe_out   <= 1'b0;
         strobe_oe    <= 1'b0;
      end else begin
         case (strobe_state)
            STROBE_IDLE: begin
               strobe_oe  <= 1'b0;
               strobe_out <= 1'b0;
               if (accept && (req_cmd == CMD_WRITE || req_cmd == CMD_WRITE_AP)) begin
                  strobe_state <= STROBE_ARMED;
               end
            end
            STROBE_ARMED: begin
               strobe_oe    <= 1'b1;
               strobe_state <= STROBE_PRE;
            end
            STROBE_PRE:  strobe_state <= STROBE_WAIT;
            STROBE_WAIT: begin
               strobe_out   <= 1'b1;
               strobe_state <= STROBE_HIGH;
            end
            STROBE_HIGH: begin
               strobe_out   <= 1'b0;
               strobe_state <= STROBE_LOW;
            end
            STROBE_LOW: begin
               strobe_oe    <= 1'b0;
               strobe_state <= STROBE_IDLE;
            end
            default: strobe_state <= STROBE_IDLE;
         endcase
      end
   end

endmodule
`default_nettype wire

/* File: design/ddr_guard_pkg.sv */
package ddr_guard_pkg;

   localparam int CORE_PERIOD_PS = 20000;
   localparam int CK_DIV         = 2;        // Memory clock is core clock halved
   localparam int NUM_BANKS      = 4;
   localparam int TIMER_W        = 12;

   typedef logic [TIMER_W-1:0] timer_type;

   // Least time: round up to whole core cycles
   function automatic int up_cycles(input int t_ps);
      return (t_ps + CORE_PERIOD_PS - 1) / CORE_PERIOD_PS;
   endfunction

   localparam int ACT_ACCESS_NS_FAST    = 15;
   localparam int ACT_ACCESS_NS_SLOW    = 18;
   localparam int ROW_ACTIVE_NS_FAST    = 40;
   localparam int ROW_ACTIVE_NS_SLOW    = 42;
   localparam real ROW_ACTIVE_MAX_NS    = 70E+3;
   localparam int ROW_CYCLE_NS_FAST     = 55;
   localparam int ROW_CYCLE_NS_SLOW     = 60;
   localparam int REFRESH_CYCLE_NS_FAST = 70;
   localparam int REFRESH_CYCLE_NS_SLOW = 72;
   localparam real REFRESH_INTERVAL_US  = 7.8;
   localparam int BANK_GAP_NS_FAST      = 10;
   localparam int BANK_GAP_NS_SLOW      = 12;
   localparam int PRECHARGE_NS_FAST     = 15;
   localparam int PRECHARGE_NS_SLOW     = 18;
   localparam int WRITE_RECOVERY_NS     = 15;
   localparam int SR_EXIT_NONREAD_NS    = 75;
   localparam int MODE_SET_CK           = 2;
   localparam int WRITE_TO_READ_CK_FAST = 2;
   localparam int WRITE_TO_READ_CK_SLOW = 1;
   localparam int SR_EXIT_READ_CK       = 200;
   localparam int WRITE_DATA_CK         = 2;  // Command to end of burst-of-two data
   localparam int CK_PERIOD_NS          = CORE_PERIOD_PS * CK_DIV / 1000;

   localparam int ACCESS_CYC_FAST  = up_cycles(ACT_ACCESS_NS_FAST * 1000);
   localparam int ACCESS_CYC_SLOW  = up_cycles(ACT_ACCESS_NS_SLOW * 1000);
   localparam int RAS_CYC_FAST     = up_cycles(ROW_ACTIVE_NS_FAST * 1000);
   localparam int RAS_CYC_SLOW     = up_cycles(ROW_ACTIVE_NS_SLOW * 1000);
   localparam int RAS_MAX_CYC      = int'($floor(ROW_ACTIVE_MAX_NS * 1000.0 / CORE_PERIOD_PS));
   localparam int RC_CYC_FAST      = up_cycles(ROW_CYCLE_NS_FAST * 1000);
   localparam int RC_CYC_SLOW      = up_cycles(ROW_CYCLE_NS_SLOW * 1000);
   localparam int RFC_CYC_FAST     = up_cycles(REFRESH_CYCLE_NS_FAST * 1000);
   localparam int RFC_CYC_SLOW     = up_cycles(REFRESH_CYCLE_NS_SLOW * 1000);
   localparam int REFI_CYC         = int'($floor(REFRESH_INTERVAL_US * 1.0E6 / CORE_PERIOD_PS));
   localparam int RRD_CYC_FAST     = up_cycles(BANK_GAP_NS_FAST * 1000);
   localparam int RRD_CYC_SLOW     = up_cycles(BANK_GAP_NS_SLOW * 1000);
   localparam int RP_CYC_FAST      = up_cycles(PRECHARGE_NS_FAST * 1000);
   localparam int RP_CYC_SLOW      = up_cycles(PRECHARGE_NS_SLOW * 1000);
   localparam int XSNR_CYC         = up_cycles(SR_EXIT_NONREAD_NS * 1000);
   localparam int MRD_CYC          = MODE_SET_CK * CK_DIV;
   localparam int WTR_CYC_FAST     = (WRITE_DATA_CK + WRITE_TO_READ_CK_FAST) * CK_DIV;
   localparam int WTR_CYC_SLOW     = (WRITE_DATA_CK + WRITE_TO_READ_CK_SLOW) * CK_DIV;
   localparam int XSRD_CYC         = SR_EXIT_READ_CK * CK_DIV;
   localparam int WBUSY_CYC        = WRITE_DATA_CK * CK_DIV + 1;
   // Whole clocks of recovery and precharge, each rounded up, after the data
   localparam int DAL_CK_FAST = (WRITE_RECOVERY_NS + CK_PERIOD_NS - 1) / CK_PERIOD_NS
                              + (PRECHARGE_NS_FAST + CK_PERIOD_NS - 1) / CK_PERIOD_NS;
   localparam int DAL_CK_SLOW = (WRITE_RECOVERY_NS + CK_PERIOD_NS - 1) / CK_PERIOD_NS
                              + (PRECHARGE_NS_SLOW + CK_PERIOD_NS - 1) / CK_PERIOD_NS;
   localparam int DAL_CYC_FAST = (WRITE_DATA_CK + DAL_CK_FAST) * CK_DIV;
   localparam int DAL_CYC_SLOW = (WRITE_DATA_CK + DAL_CK_SLOW) * CK_DIV;

   localparam int AUTO_PRE_BIT = 10;

   // Command pins {cs_n, ras_n, cas_n, we_n}
   localparam logic [3:0] PINS_NOP       = 4'h7;
   localparam logic [3:0] PINS_ACTIVATE  = 4'h3;
   localparam logic [3:0] PINS_READ      = 4'h5;
   localparam logic [3:0] PINS_WRITE     = 4'h4;
   localparam logic [3:0] PINS_PRECHARGE = 4'h2;
   localparam logic [3:0] PINS_REFRESH   = 4'h1;
   localparam logic [3:0] PINS_MODE_SET  = 4'h0;

   typedef enum logic [3:0] {
      CMD_NOP, CMD_ACTIVATE, CMD_READ, CMD_WRITE, CMD_WRITE_AP, CMD_PRECHARGE,
      CMD_REFRESH, CMD_MODE_SET, CMD_SELF_REFRESH_ENTER, CMD_SELF_REFRESH_EXIT
   } command_type;

   typedef enum logic [2:0] {
      STROBE_IDLE, STROBE_ARMED, STROBE_PRE, STROBE_WAIT, STROBE_HIGH, STROBE_LOW
   } strobe_state_type;

endpackage

/* File: verif/ddr_guard_asserts.sv */
`timescale 1ns/10ps
`default_nettype none
module ddr_guard_asserts
   import ddr_guard_pkg::*;
(
   input wire logic        core_clk,
   input wire logic        rst,
   input wire logic        fast_grade,
   input wire logic        req_done,
   input wire logic        mem_ck,
   input wire logic        mem_cke,
   input wire logic        mem_cs_n,
   input wire logic        mem_ras_n,
   input wire logic        mem_cas_n,
   input wire logic        mem_we_n,
   input wire logic [1:0]  mem_ba,
   input wire logic [12:0] mem_addr,
   input wire logic        strobe_out,
   input wire logic        strobe_oe
);
   timer_type  since_act [NUM_BANKS];
   timer_type  since_wap [NUM_BANKS];
   timer_type  since_ref, since_mode, since_wr, since_wake;
   logic       slept;
   logic       cke_q;
   logic [3:0] cmd;

   // Pins count only while the done pulse stands
   assign cmd = req_done ? {mem_cs_n, mem_ras_n, mem_cas_n, mem_we_n} : PINS_NOP;

   function automatic timer_type bump(input timer_type v, input logic hit);
      return hit ? timer_type'(1) : ((&v) ? v : v + 1'b1);
   endfunction

   // Saturating cycles since each refresh, mode set, write, activate and auto-precharge write
   always_ff @(posedge core_clk) begin
      if (rst) begin
         since_ref  <= '1;
         since_mode <= '1;
         since_wr   <= '1;
         since_act  <= '{default: '1};
         since_wap  <= '{default: '1};
      end else begin
         since_ref  <= bump(since_ref, cmd == PINS_REFRESH);
         since_mode <= bump(since_mode, cmd == PINS_MODE_SET);
         since_wr   <= bump(since_wr, cmd == PINS_WRITE);
         for (int b = 0; b < NUM_BANKS; b++) begin
            since_act[b] <= bump(since_act[b], cmd == PINS_ACTIVATE && mem_ba == b);
            since_wap[b] <= bump(since_wap[b], cmd == PINS_WRITE && mem_addr[AUTO_PRE_BIT] && mem_ba == b);
         end
      end
   end

   // Wake time counts from the first command after sleep
   always_ff @(posedge core_clk) begin
      if (rst) begin
         slept      <= 1'b0;
         cke_q      <= 1'b0;
         since_wake <= '1;
      end else begin
         cke_q      <= mem_cke;
         since_wake <= bump(since_wake, slept && req_done);
         if (cke_q && !mem_cke) slept <= 1'b1;
         else if (req_done) slept <= 1'b0;
      end
   end

   act_access_a: assert property (@(posedge core_clk) disable iff (rst)
      (cmd == PINS_READ || cmd == PINS_WRITE) |-> since_act[mem_ba] >= (fast_grade ? ACCESS_CYC_FAST : ACCESS_CYC_SLOW))
      else $error("access too soon");
   row_active_a: assert property (@(posedge core_clk) disable iff (rst)
      cmd == PINS_PRECHARGE |-> since_act[mem_ba] >= (fast_grade ? RAS_CYC_FAST : RAS_CYC_SLOW))
      else $error("precharge too soon");
   row_cycle_a: assert property (@(posedge core_clk) disable iff (rst)
      cmd == PINS_ACTIVATE |-> since_act[mem_ba] >= (fast_grade ? RC_CYC_FAST : RC_CYC_SLOW))
      else $error("activate too soon");
   refresh_gap_a: assert property (@(posedge core_clk) disable iff (rst)
      (cmd == PINS_ACTIVATE || cmd == PINS_REFRESH) |-> since_ref >= (fast_grade ? RFC_CYC_FAST : RFC_CYC_SLOW))
      else $error("refresh gap short");
   mode_gap_a: assert property (@(posedge core_clk) disable iff (rst)
      cmd != PINS_NOP |-> since_mode >= MRD_CYC)
      else $error("mode set gap short");
   write_read_a: assert property (@(posedge core_clk) disable iff (rst)
      cmd == PINS_READ |-> since_wr >= (fast_grade ? WTR_CYC_FAST : WTR_CYC_SLOW))
      else $error("read too soon after write");
   autopre_gap_a: assert property (@(posedge core_clk) disable iff (rst)
      cmd == PINS_ACTIVATE |-> since_wap[mem_ba] >= (fast_grade ? DAL_CYC_FAST : DAL_CYC_SLOW))
      else $error("auto precharge gap short");
   wake_other_a: assert property (@(posedge core_clk) disable iff (rst)
      (cmd != PINS_NOP && cmd != PINS_READ) |-> since_wake >= XSNR_CYC)
      else $error("command too soon after wake");
   wake_read_a: assert property (@(posedge core_clk) disable iff (rst)
      cmd == PINS_READ |-> since_wake >= XSRD_CYC)
      else $error("read too soon after wake");
   strobe_first_a: assert property (@(posedge core_clk) disable iff (rst)
      cmd == PINS_WRITE |=> (strobe_oe && !strobe_out) [*2] ##1 (strobe_oe && strobe_out))
      else $error("first strobe edge misplaced");
   strobe_width_a: assert property (@(posedge core_clk) disable iff (rst)
      $rose(strobe_out) |=> (strobe_oe && !strobe_out) ##1 !strobe_oe)
      else $error("strobe phase wrong");
   strobe_fall_a: assert property (@(posedge core_clk) disable iff (rst)
      $fell(strobe_out) |-> $fell(mem_ck) && strobe_oe)
      else $error("strobe fall off centre");
endmodule

bind ddr_command_timing_guard ddr_guard_asserts u_chk (.core_clk(core_clk), .rst(rst), .fast_grade(fast_grade),
   .req_done(req_done), .mem_ck(mem_ck), .mem_cke(mem_cke), .mem_cs_n(mem_cs_n), .mem_ras_n(mem_ras_n),
   .mem_cas_n(mem_cas_n), .mem_we_n(mem_we_n), .mem_ba(mem_ba), .mem_addr(mem_addr), .strobe_out(strobe_out),
   .strobe_oe(strobe_oe));
`default_nettype wire

/* File: verif/sdram_device_model.sv */
`timescale 1ns/10ps
`default_nettype none
module sdram_device_model
   import ddr_guard_pkg::*;
(
   input wire logic        mem_ck,
   input wire logic        mem_cke,
   input wire logic [3:0]  pins,
   input wire logic [1:0]  mem_ba,
   input wire logic [12:0] mem_addr,
   input wire logic        strobe_out,
   input wire logic        strobe_oe,
   output var int          act_count,
   output var int          strobe_count,
   output var int          misuse_count,
   output var logic [3:0]  open_banks
);
   // Start empty; the device sees no reset of its own
   initial begin
      act_count = 0;
      strobe_count = 0;
      misuse_count = 0;
      open_banks = 4'h0;
   end

   // Latch on the rising memory clock; misuse is counted
   always @(posedge mem_ck) begin
      if (mem_cke) begin
         case (pins)
            PINS_ACTIVATE: begin
               if (open_banks[mem_ba]) misuse_count++;
               open_banks[mem_ba] = 1'b1;
               act_count++;
            end
            PINS_READ, PINS_WRITE: begin
               if (!open_banks[mem_ba]) misuse_count++;
               if (pins == PINS_WRITE && mem_addr[AUTO_PRE_BIT]) open_banks[mem_ba] = 1'b0;
            end
            PINS_PRECHARGE: open_banks[mem_ba] = 1'b0;
            PINS_REFRESH: if (|open_banks) misuse_count++;
            default: ;
         endcase
      end
   end

   // Each strobe rise while driven latches one data pair
   always @(posedge strobe_out) if (strobe_oe) strobe_count++;
endmodule
`default_nettype wire

/* File: verif/test_ddr_command_timing_guard.sv */
`timescale 1ns/10ps
`default_nettype none
module test_ddr_command_timing_guard
   import ddr_guard_pkg::*;
;
   typedef struct {
      command_type cmd;
      logic [3:0]  pins;
      logic [1:0]  bank;
      logic [12:0] addr;
      int          ref_row;
      int          gap;
   } row_type;

   logic        core_clk, rst, fast_grade, req_valid, req_done;
   command_type req_cmd;
   logic [1:0]  req_bank, mem_ba;
   logic [12:0] req_addr, mem_addr;
   logic        mem_ck, mem_ck_n, mem_cke, mem_cs_n, mem_ras_n, mem_cas_n, mem_we_n;
   logic        strobe_out, strobe_oe, refresh_due;
   logic [3:0]  bank_overdue, open_banks;
   logic [18:0] seen;
   int          act_count, strobe_count, misuse_count, fails, checked;
   int          cyc = 0;
   int          t_done [24];

   // Fast grade for the first twenty rows, second grade after
   row_type rows [24] = '{
      '{CMD_MODE_SET, PINS_MODE_SET, 0, 'h031, 0, 0}, '{CMD_ACTIVATE, PINS_ACTIVATE, 0, 'h123, 0, MRD_CYC},
      '{CMD_ACTIVATE, PINS_ACTIVATE, 1, 'h045, 1, RRD_CYC_FAST}, '{CMD_WRITE, PINS_WRITE, 0, 'h410, 1, ACCESS_CYC_FAST},
      '{CMD_READ, PINS_READ, 0, 'h010, 3, WTR_CYC_FAST}, '{CMD_PRECHARGE, PINS_PRECHARGE, 0, 'h400, 1, RAS_CYC_FAST},
      '{CMD_ACTIVATE, PINS_ACTIVATE, 0, 'h077, 1, RC_CYC_FAST}, '{CMD_WRITE_AP, PINS_WRITE, 1, 'h020, 2, ACCESS_CYC_FAST},
      '{CMD_ACTIVATE, PINS_ACTIVATE, 1, 'h046, 7, DAL_CYC_FAST}, '{CMD_PRECHARGE, PINS_PRECHARGE, 0, 0, 6, RAS_CYC_FAST},
      '{CMD_PRECHARGE, PINS_PRECHARGE, 1, 0, 8, RAS_CYC_FAST}, '{CMD_REFRESH, PINS_REFRESH, 0, 0, 8, RC_CYC_FAST},
      '{CMD_REFRESH, PINS_REFRESH, 0, 0, 11, RFC_CYC_FAST}, '{CMD_ACTIVATE, PINS_ACTIVATE, 2, 'h100, 12, RFC_CYC_FAST},
      '{CMD_PRECHARGE, PINS_PRECHARGE, 2, 0, 13, RAS_CYC_FAST}, '{CMD_SELF_REFRESH_ENTER, PINS_REFRESH, 0, 0, 14, 0},
      '{CMD_SELF_REFRESH_EXIT, PINS_NOP, 0, 0, 15, 0}, '{CMD_ACTIVATE, PINS_ACTIVATE, 3, 'h200, 16, XSNR_CYC},
      '{CMD_READ, PINS_READ, 3, 'h008, 16, XSRD_CYC}, '{CMD_PRECHARGE, PINS_PRECHARGE, 3, 0, 17, RAS_CYC_FAST},
      '{CMD_ACTIVATE, PINS_ACTIVATE, 0, 'h055, 19, 0}, '{CMD_WRITE, PINS_WRITE, 0, 'h004, 20, ACCESS_CYC_SLOW},
      '{CMD_READ, PINS_READ, 0, 'h004, 21, WTR_CYC_SLOW}, '{CMD_PRECHARGE, PINS_PRECHARGE, 0, 0, 20, RAS_CYC_SLOW}};

   ddr_command_timing_guard i_dut (.*);

   sdram_device_model i_mem (.pins({mem_cs_n, mem_ras_n, mem_cas_n, mem_we_n}), .*);

   // Free-running 50 MHz clock and a cycle stamp for gap measurement
   initial begin
      core_clk = 1'b0;
      forever #10 core_clk = ~core_clk;
   end
   always @(posedge core_clk) cyc <= cyc + 1;

   task automatic check_bits(input logic [19:0] got, input logic [19:0] exp);
      checked++;
      if (got !== exp) begin
         fails++;
         $display("[FAIL] %0t got %h expected %h", $time, got, exp);
      end
   endtask

   task automatic check_min(input int got, input int low);
      checked++;
      if (got < low) begin
         fails++;
         $display("[FAIL] %0t got %h below %h", $time, got, low);
      end
   endtask

   // Hold the request until done, capture the pins, drop it and wait one edge
   task automatic issue(input command_type c, input logic [1:0] b, input logic [12:0] a, output int t);
      int n;
      n = 0;
      req_valid <= 1'b1;
      req_cmd <= c;
      req_bank <= b;
      req_addr <= a;
      @(posedge core_clk);
      while (req_done !== 1'b1 && n < 1000) begin
         @(posedge core_clk);
         n++;
      end
      t = cyc;
      seen = {mem_cs_n, mem_ras_n, mem_cas_n, mem_we_n, mem_ba, mem_addr};
      req_valid <= 1'b0;
      @(posedge core_clk);
   endtask

   task automatic complete_run;
      $display("checked %0d fails %0d", checked, fails);
      if (fails == 0 && checked > 0)
         $display("Testbench passed");
      else
         $display("Testbench failed");
      $finish;
   endtask

   // Hang guard, well above the expected run
   initial begin
      repeat (20000) @(posedge core_clk);
      fails++;
      complete_run;
   end

   initial begin
      int          n, n_act, n_wr, t0;
      logic [12:0] exp_addr;
      {rst, fast_grade, req_valid, req_bank, req_addr, fails, checked, n_act, n_wr} = '0;
      rst = 1'b1;
      req_cmd = CMD_NOP;
      repeat (12) @(posedge core_clk);
      rst <= 1'b0;
      for (int i = 0; i < 24; i++) begin
         fast_grade <= (i < 20);
         issue(rows[i].cmd, rows[i].bank, rows[i].addr, t_done[i]);
         check_bits(20'(seen[18:15]), 20'(rows[i].pins));
         check_min(t_done[i] - t_done[rows[i].ref_row], rows[i].gap);
         exp_addr = rows[i].addr;
         if (rows[i].cmd inside {CMD_WRITE, CMD_PRECHARGE}) exp_addr[AUTO_PRE_BIT] = 1'b0;
         if (rows[i].cmd == CMD_WRITE_AP) exp_addr[AUTO_PRE_BIT] = 1'b1;
         if (rows[i].pins != PINS_REFRESH && rows[i].pins != PINS_NOP)
            check_bits(20'(seen[14:0]), 20'({rows[i].bank, exp_addr}));
         if (rows[i].cmd == CMD_ACTIVATE) n_act++;
         if (rows[i].pins == PINS_WRITE) n_wr++;
      end
      repeat (8) @(posedge core_clk);
      check_bits(20'(act_count), 20'(n_act));
      check_bits(20'(strobe_count), 20'(n_wr));
      check_bits(20'({misuse_count[15:0], open_banks}), 20'h0);
      // Read to a closed bank is refused; reset then returns the outputs to their idle values
      req_valid <= 1'b1;
      req_cmd <= CMD_READ;
      req_bank <= 2'h2;
      n = 0;
      repeat (30) @(posedge core_clk) if (req_done === 1'b1) n++;
      check_bits(20'(n), 20'h0);
      rst <= 1'b1;
      req_valid <= 1'b0;
      repeat (2) @(posedge core_clk);
      check_bits({mem_ck, mem_ck_n, mem_cke, strobe_oe, req_done, refresh_due, bank_overdue, mem_cs_n, mem_ras_n,
                  mem_cas_n, mem_we_n, 2'h0}, {6'h10, 4'h0, PINS_NOP, 2'h0});
      rst <= 1'b0;
      n = 0;
      while (refresh_due !== 1'b1 && n < 600) begin
         @(posedge core_clk);
         n++;
      end
      check_min(n, REFI_CYC - 4);
      check_min(REFI_CYC + 4, n);
      issue(CMD_REFRESH, 2'h0, 13'h0000, t0);
      repeat (2) @(posedge core_clk);
      check_bits(20'(refresh_due), 20'h0);
      issue(CMD_ACTIVATE, 2'h1, 13'h0ABC, t0);
      while (bank_overdue[1] !== 1'b1 && cyc - t0 < 4000) @(posedge core_clk);
      check_min(cyc - t0, RAS_MAX_CYC - 2);
      check_min(RAS_MAX_CYC + 4, cyc - t0);
      check_bits(20'(bank_overdue), 20'h2);
      issue(CMD_PRECHARGE, 2'h1, 13'h0000, t0);
      repeat (2) @(posedge core_clk);
      check_bits(20'(bank_overdue), 20'h0);
      complete_run;
   end
endmodule
`default_nettype wire
